// ==== design/uart_ctrl_defines.vh ====
// Purpose: register offsets, field positions, codes and timing counts for the serial control block
// Assumes: 8-bit register bus, three address lines
// Notes: definitions only
`ifndef UART_CTRL_DEFINES_VH
`define UART_CTRL_DEFINES_VH

// register offsets on the three address lines
`define ADDR_DATA      3'h0
`define ADDR_IRQ_EN    3'h1
`define ADDR_IDENT     3'h2
`define ADDR_MODEM_CTL 3'h4
`define ADDR_LINE_STAT 3'h5
`define ADDR_MODEM_STS 3'h6
`define ADDR_SCRATCH   3'h7

// interrupt enable fields
`define IE_RX_DATA  0
`define IE_TX_EMPTY 1
`define IE_LINE     2
`define IE_MODEM    3
`define IE_MASK     8'h0F

// fifo control fields
`define FC_ENABLE   0
`define FC_RX_FLUSH 1
`define FC_TX_FLUSH 2
`define FC_DMA_MODE 3
`define FC_TRIG_LO  6
`define FC_TRIG_HI  7

// rx trigger levels in bytes
`define TRIG_LVL0 5'h01
`define TRIG_LVL1 5'h04
`define TRIG_LVL2 5'h08
`define TRIG_LVL3 5'h0E

// modem control fields
`define MC_DTR  0
`define MC_RTS  1
`define MC_USER_OUTPUT_1 2
`define MC_USER_OUTPUT_2 3
`define MC_LOOP 4
`define MC_MASK 8'h1F

// identification codes, bits 3:0
`define ID_NONE    4'h1
`define ID_LINE    4'h6
`define ID_RX_DATA 4'h4
`define ID_TIMEOUT 4'hC
`define ID_TX_MT   4'h2
`define ID_MODEM   4'h0

// reset values
`define RST_IRQ_EN    8'h00
`define RST_MODEM_CTL 8'h00
`define RST_SCRATCH   8'h00

// receive timeout: character times, 16x ticks per bit
`define TIMEOUT_CHARS 4
`define TICKS_PER_BIT 16

`endif

// ==== design/uart_irq_fifo_modem_ctrl.v ====
// Purpose: interrupt enables, scratch, fifo control, modem control/status and rx timeout of a serial element
// Assumes: all inputs synchronous to mclk; rd_stb/wr_stb one-cycle pulses per access
// Notes: shift registers, divisor and line-status error logic sit outside and meet this block at plain ports
// Summary of operation
// RULE1: enable bits 0-3 gate rx data, tx empty, line status, modem interrupts.
// RULE2: all enables clear keeps interrupt low, ident idle; status keeps updating.
// RULE3: interrupt enable bits 4-7 always read zero.
// RULE4: scratch register stores and returns any byte, affecting nothing else.
// RULE5: fifo control is write-only, shares address with read-only identification.
// RULE6: bit 0 enables both fifos; clearing it empties them.
// RULE7: other fifo control bits ignored unless bit 0 is set in that write.
// RULE8: bit 1 flushes rx fifo, self-clears, shift register untouched.
// RULE9: bit 2 flushes tx fifo the same way.
// RULE10: bit 3 with fifos on selects dma request mode 1.
// RULE11: bits 7:6 pick rx trigger of 1, 4, 8 or 14 bytes.
// RULE12: modem control bits 0-3 drive dtr, rts, user_output_1, user_output_2 pins inverted.
// RULE13: loopback holds serial out high, feeds tx to rx, loops modem lines.
// RULE14: in loopback modem interrupts come from modem control bits 0-3.
// RULE15: modem control bits 5-7 always read zero.
// RULE16: change flags set on input transitions, all cleared by status read.
// RULE17: flags for cts, dsr, carrier on any change; ring only on->off.
// RULE18: any change flag set raises a modem status interrupt condition.
// RULE19: status bits 4-7 show inverted inputs, or control bits in loopback.
// RULE20: rx timeout after 4 idle character times with data, fifo and enable.
// RULE21: reading an rx character clears timeout and restarts its counter.
// RULE22: rx data interrupt follows fill level at or above trigger.
// RULE23: enables all zero: no trigger or timeout shown, fifos still buffer.
// RULE24: identification bits 7:6 read one while fifos enabled.
// RULE25: timeout shows as 1100 at second priority, cleared by rx read.
// RULE26: interrupt output high whenever an enabled condition is pending.
// RULE27: reset clears enables, fifo control, modem control and change flags.
`timescale 1ns/1ps
`include "uart_ctrl_defines.vh"

// synchronous fifo with registered flags and registered head word
module sync_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire mclk,
  input wire sys_rst,
  input wire flush,
  input wire [AW:0] cap,
  input wire in_valid,
  output reg in_ready,
  input wire [WIDTH-1:0] in_data,
  output reg out_valid,
  input wire out_ready,
  output reg [WIDTH-1:0] out_data,
  output reg [AW:0] count
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_q;
  reg [AW-1:0] rd_ptr_q;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;
  wire [AW-1:0] rd_next = pop ? rd_ptr_q + 1'b1 : rd_ptr_q;
  wire [AW:0] count_d = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // storage; no reset needed on the array
  always @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr_q] <= in_data;
    end
  end

  // pointers, count and registered flags; cap shrinks depth for single-character mode
  always @(posedge mclk) begin
    if (sys_rst || flush) begin
      wr_ptr_q <= {AW{1'b0}};
      rd_ptr_q <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
      in_ready <= 1'b0;
      out_valid <= 1'b0;
      out_data <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      rd_ptr_q <= rd_next;
      count <= count_d;
      in_ready <= (count_d < cap);
      out_valid <= (count_d != {(AW+1){1'b0}});
      // new head is the word just written when the fifo drains to it
      if (push && (wr_ptr_q == rd_next)) begin
        out_data <= in_data;
      end else begin
        out_data <= mem[rd_next];
      end
    end
  end
endmodule // sync_fifo

module uart_irq_fifo_modem_ctrl #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  input wire mclk,
  input wire sys_rst,
  input wire chip_sel,
  input wire [2:0] reg_addr,
  input wire wr_stb,
  input wire rd_stb,
  input wire [7:0] wr_data,
  output reg [7:0] rd_data,
  output reg irq_out,
  output reg rx_dma_request_n,
  output reg tx_dma_request_n,
  output reg dtr_n,
  output reg rts_n,
  output reg user_output_1_n,
  output reg user_output_2_n,
  input wire cts_n,
  input wire dsr_n,
  input wire ring_n,
  input wire carrier_detect_in_n,
  output reg serial_tx_pin,
  input wire serial_rx_pin,
  input wire tx_shift_out,
  output reg rx_serial_in,
  input wire rx_tick16,
  input wire [3:0] char_bits,
  input wire line_err_pending,
  input wire rx_char_valid,
  input wire [7:0] rx_char_data,
  output wire rx_char_ready,
  output wire tx_char_valid,
  output wire [7:0] tx_char_data,
  input wire tx_char_ready
);
  localparam [FIFO_AW:0] CAP_FULL = FIFO_DEPTH;
  localparam [FIFO_AW:0] CAP_ONE = 1;

  reg [3:0] irq_en_q;
  reg [7:0] scratch_q;
  reg fifo_en_q;
  reg dma_mode_q;
  reg [1:0] trig_sel_q;
  reg [4:0] mctl_q;
  reg [3:0] mstat_q;
  reg [3:0] mstat_prev_q;
  reg [3:0] chg_q;
  reg thre_pend_q;
  reg tx_empty_prev_q;
  reg [9:0] to_cnt_q;
  reg to_pend_q;
  reg rx_m1_act_q;
  reg [3:0] ident_d;
  reg [4:0] trig_lvl;
  reg [7:0] rd_mux;

  wire rd_acc = chip_sel & rd_stb;
  wire wr_acc = chip_sel & wr_stb;
  wire fcr_wr = wr_acc & (reg_addr == `ADDR_IDENT);
  wire fcr_on = wr_data[`FC_ENABLE];
  // clearing the enable empties both; other bits only count with enable set
  wire rx_flush = fcr_wr & (~fcr_on | wr_data[`FC_RX_FLUSH]); // see RULE6 see RULE8
  wire tx_flush = fcr_wr & (~fcr_on | wr_data[`FC_TX_FLUSH]); // see RULE9
  wire [FIFO_AW:0] cap = fifo_en_q ? CAP_FULL : CAP_ONE;

  wire [7:0] rx_head;
  wire rx_has;
  wire [FIFO_AW:0] rx_count;
  wire tx_in_ready;
  wire [FIFO_AW:0] tx_count;
  wire rx_pop = rd_acc & (reg_addr == `ADDR_DATA) & rx_has;
  wire rx_push = rx_char_valid & rx_char_ready;
  wire tx_push = wr_acc & (reg_addr == `ADDR_DATA);
  wire tx_empty = (tx_count == {(FIFO_AW+1){1'b0}});
  wire tx_full = ~tx_in_ready;

  // receive path buffer; rx_char_ready is its registered ready, stalls the receiver
  sync_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) rx_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .flush(rx_flush),
    .cap(cap),
    .in_valid(rx_char_valid),
    .in_ready(rx_char_ready),
    .in_data(rx_char_data),
    .out_valid(rx_has),
    .out_ready(rx_pop),
    .out_data(rx_head),
    .count(rx_count)
  );

  // transmit path buffer; writes while full are dropped as on the real holding register
  sync_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) tx_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .flush(tx_flush),
    .cap(cap),
    .in_valid(tx_push),
    .in_ready(tx_in_ready),
    .in_data(wr_data),
    .out_valid(tx_char_valid),
    .out_ready(tx_char_ready),
    .out_data(tx_char_data),
    .count(tx_count)
  );

  // trigger level decode
  always @* begin
    case (trig_sel_q)
      2'b00: trig_lvl = `TRIG_LVL0; // see RULE11
      2'b01: trig_lvl = `TRIG_LVL1;
      2'b10: trig_lvl = `TRIG_LVL2;
      2'b11: trig_lvl = `TRIG_LVL3;
      default: trig_lvl = `TRIG_LVL0;
    endcase
  end

  // pending conditions, each gated by its enable
  wire rx_trig_hit = fifo_en_q ? (rx_count >= trig_lvl) : rx_has;
  wire line_irq = irq_en_q[`IE_LINE] & line_err_pending; // see RULE1
  wire rda_irq = irq_en_q[`IE_RX_DATA] & rx_trig_hit; // see RULE22 see RULE23
  wire to_irq = irq_en_q[`IE_RX_DATA] & fifo_en_q & to_pend_q; // see RULE20 see RULE23
  wire thre_irq = irq_en_q[`IE_TX_EMPTY] & thre_pend_q;
  wire ms_irq = irq_en_q[`IE_MODEM] & (chg_q != 4'h0); // see RULE18 see RULE14

  // identification priority: line, rx data/timeout, tx empty, modem
  always @* begin
    if (line_irq) begin
      ident_d = `ID_LINE;
    end else if (rda_irq) begin
      ident_d = `ID_RX_DATA;
    end else if (to_irq) begin
      ident_d = `ID_TIMEOUT; // see RULE25
    end else if (thre_irq) begin
      ident_d = `ID_TX_MT;
    end else if (ms_irq) begin
      ident_d = `ID_MODEM;
    end else begin
      ident_d = `ID_NONE; // see RULE2
    end
  end

  // modem line sources: pins inverted, or control bits when looped back
  wire loop = mctl_q[`MC_LOOP];
  wire [3:0] mstat_src = loop ? {mctl_q[`MC_USER_OUTPUT_2], mctl_q[`MC_USER_OUTPUT_1], mctl_q[`MC_DTR], mctl_q[`MC_RTS]} // see RULE13
                              : {~carrier_detect_in_n, ~ring_n, ~dsr_n, ~cts_n}; // see RULE19
  wire [3:0] chg_set = {mstat_q[3] ^ mstat_prev_q[3],
                        ~mstat_q[2] & mstat_prev_q[2],
                        mstat_q[1] ^ mstat_prev_q[1],
                        mstat_q[0] ^ mstat_prev_q[0]}; // see RULE17
  wire msr_rd = rd_acc & (reg_addr == `ADDR_MODEM_STS);

  // read data mux; reserved bits read zero
  always @* begin
    case (reg_addr)
      `ADDR_DATA: rd_mux = rx_head;
      `ADDR_IRQ_EN: rd_mux = {4'h0, irq_en_q}; // see RULE3
      `ADDR_IDENT: rd_mux = {fifo_en_q, fifo_en_q, 2'b00, ident_d}; // see RULE5 see RULE24
      `ADDR_MODEM_CTL: rd_mux = {3'b000, mctl_q}; // see RULE15
      `ADDR_LINE_STAT: rd_mux = {1'b0, tx_empty, tx_empty, 4'h0, rx_has};
      `ADDR_MODEM_STS: rd_mux = {mstat_q, chg_q};
      `ADDR_SCRATCH: rd_mux = scratch_q; // see RULE4
      default: rd_mux = 8'h00;
    endcase
  end

  // software-written registers
  always @(posedge mclk) begin
    if (sys_rst) begin
      irq_en_q <= 4'h0; // see RULE27
      scratch_q <= `RST_SCRATCH;
      fifo_en_q <= 1'b0;
      dma_mode_q <= 1'b0;
      trig_sel_q <= 2'b00;
      mctl_q <= 5'h00;
    end else if (wr_acc) begin
      case (reg_addr)
        `ADDR_IRQ_EN: irq_en_q <= wr_data[3:0];
        `ADDR_SCRATCH: scratch_q <= wr_data;
        `ADDR_MODEM_CTL: mctl_q <= wr_data[4:0];
        `ADDR_IDENT: begin
          fifo_en_q <= fcr_on; // see RULE6
          if (fcr_on) begin // see RULE7
            dma_mode_q <= wr_data[`FC_DMA_MODE];
            trig_sel_q <= wr_data[`FC_TRIG_HI:`FC_TRIG_LO];
          end
        end
        default: scratch_q <= scratch_q;
      endcase
    end
  end

  // modem status sampling and sticky change flags; a new change beats the read clear
  always @(posedge mclk) begin
    if (sys_rst) begin
      mstat_q <= 4'h0;
      mstat_prev_q <= 4'h0;
      chg_q <= 4'h0; // see RULE27
    end else begin
      mstat_q <= mstat_src;
      mstat_prev_q <= mstat_q;
      chg_q <= (msr_rd ? 4'h0 : chg_q) | chg_set; // see RULE16
    end
  end

  // tx empty interrupt: set on going empty or on enabling while empty
  always @(posedge mclk) begin
    if (sys_rst) begin
      thre_pend_q <= 1'b0;
      tx_empty_prev_q <= 1'b1;
    end else begin
      tx_empty_prev_q <= tx_empty;
      if ((tx_empty & ~tx_empty_prev_q) ||
          (wr_acc && reg_addr == `ADDR_IRQ_EN && wr_data[`IE_TX_EMPTY] && !irq_en_q[`IE_TX_EMPTY] && tx_empty)) begin
        thre_pend_q <= 1'b1;
      end else if (tx_push || (rd_acc && reg_addr == `ADDR_IDENT && ident_d == `ID_TX_MT)) begin
        thre_pend_q <= 1'b0;
      end
    end
  end

  // rx timeout counts 16x ticks; restarted by arrivals, reads or an empty fifo
  localparam [9:0] TO_SCALE = `TIMEOUT_CHARS * `TICKS_PER_BIT;
  wire [9:0] to_limit = TO_SCALE * {6'h00, char_bits}; // see RULE20
  always @(posedge mclk) begin
    if (sys_rst) begin
      to_cnt_q <= 10'h000;
      to_pend_q <= 1'b0;
    end else if (!fifo_en_q || !rx_has || rx_push || rx_pop || rx_flush) begin
      to_cnt_q <= 10'h000; // see RULE21
      to_pend_q <= 1'b0;
    end else if (rx_tick16) begin
      if (to_cnt_q >= to_limit - 10'h001) begin
        to_pend_q <= 1'b1;
      end else begin
        to_cnt_q <= to_cnt_q + 10'h001;
      end
    end
  end

  // registered outputs: read data, interrupt, pins, dma requests
  always @(posedge mclk) begin
    if (sys_rst) begin
      rd_data <= 8'h00;
      irq_out <= 1'b0;
      dtr_n <= 1'b1;
      rts_n <= 1'b1;
      user_output_1_n <= 1'b1;
      user_output_2_n <= 1'b1;
      serial_tx_pin <= 1'b1;
      rx_serial_in <= 1'b1;
      rx_dma_request_n <= 1'b1;
      tx_dma_request_n <= 1'b1;
      rx_m1_act_q <= 1'b0;
    end else begin
      if (rd_acc) begin
        rd_data <= rd_mux;
      end
      irq_out <= line_irq | rda_irq | to_irq | thre_irq | ms_irq; // see RULE26
      dtr_n <= ~mctl_q[`MC_DTR]; // see RULE12
      rts_n <= ~mctl_q[`MC_RTS];
      user_output_1_n <= ~mctl_q[`MC_USER_OUTPUT_1];
      user_output_2_n <= ~mctl_q[`MC_USER_OUTPUT_2];
      serial_tx_pin <= loop | tx_shift_out; // see RULE13
      rx_serial_in <= loop ? tx_shift_out : serial_rx_pin;
      // mode 1 rx request latches on trigger or timeout, drops once drained
      if (!rx_has) begin
        rx_m1_act_q <= 1'b0;
      end else if (rx_trig_hit || to_pend_q) begin
        rx_m1_act_q <= 1'b1;
      end
      if (fifo_en_q && dma_mode_q) begin // see RULE10
        rx_dma_request_n <= ~rx_m1_act_q;
        tx_dma_request_n <= tx_full;
      end else begin
        rx_dma_request_n <= ~rx_has;
        tx_dma_request_n <= ~tx_empty;
      end
    end
  end
endmodule // uart_irq_fifo_modem_ctrl

// ==== tb/uart_ctrl_checker.sv ====
// Purpose: port assertions for the serial control block
// Assumes: one clock, sync reset, accesses never overlap
// Notes: shadows of written registers judge reads and pins
`timescale 1ns/1ps
module uart_ctrl_checker (
  input wire mclk,
  input wire sys_rst,
  input wire chip_sel,
  input wire [2:0] reg_addr,
  input wire wr_stb,
  input wire rd_stb,
  input wire [7:0] wr_data,
  input wire [7:0] rd_data,
  input wire irq_out,
  input wire dtr_n,
  input wire rts_n,
  input wire user_output_1_n,
  input wire user_output_2_n,
  input wire serial_tx_pin,
  input wire serial_rx_pin,
  input wire tx_shift_out,
  input wire rx_serial_in
);
  reg [7:0] ie_q;
  reg [7:0] mc_q;
  reg [7:0] sp_q;
  reg fe_q;
  reg [1:0] age_q;
  wire wr = chip_sel && wr_stb;
  wire rd = chip_sel && rd_stb && !wr_stb;
  wire ok = age_q == 2'h3; // registered pins need time to land
  wire lb = mc_q[4];
  wire [3:0] lp = {mc_q[3], mc_q[2], mc_q[0], mc_q[1]};
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // shadows follow the writes
  always @(posedge mclk) begin
    if (sys_rst) begin
      ie_q <= 8'h00;
      mc_q <= 8'h00;
      sp_q <= 8'h00;
      fe_q <= 1'b0;
      age_q <= 2'h3;
    end else begin
      if (wr && reg_addr == 3'h1) ie_q <= wr_data;
      if (wr && reg_addr == 3'h4) mc_q <= wr_data;
      if (wr && reg_addr == 3'h7) sp_q <= wr_data;
      if (wr && reg_addr == 3'h2) fe_q <= wr_data[0];
      if (wr && reg_addr == 3'h4) age_q <= 2'h0;
      else if (!ok) age_q <= age_q + 2'h1;
    end
  end
  AST_PINS: assert property (ok |-> {user_output_2_n, user_output_1_n, rts_n, dtr_n} == ~mc_q[3:0])
    else $error("modem pins wrong");
  AST_SERIAL_TX_PIN_LOOP: assert property (ok && lb |-> serial_tx_pin)
    else $error("serial out not high in loopback");
  AST_SERIAL_TX_PIN_NORM: assert property (ok && !lb |=> serial_tx_pin == $past(tx_shift_out))
    else $error("serial out not from shifter");
  AST_RX_FEED: assert property (ok |=> rx_serial_in == ($past(lb) ? $past(tx_shift_out) : $past(serial_rx_pin)))
    else $error("receiver feed wrong");
  AST_IRQ_OFF: assert property ((ie_q[3:0] == 4'h0) [*3] |-> !irq_out)
    else $error("interrupt with all enables off");
  AST_RD_IE: assert property (rd && reg_addr == 3'h1 |=> rd_data == ($past(ie_q) & 8'h0F))
    else $error("enable readback wrong");
  AST_RD_MC: assert property (rd && reg_addr == 3'h4 |=> rd_data == ($past(mc_q) & 8'h1F))
    else $error("modem control readback wrong");
  AST_RD_SP: assert property (rd && reg_addr == 3'h7 |=> rd_data == $past(sp_q))
    else $error("scratch readback wrong");
  AST_IDENT: assert property (rd && reg_addr == 3'h2 |=> rd_data[7:4] == {$past(fe_q), $past(fe_q), 2'h0})
    else $error("ident mode bits wrong");
  AST_MS_LOOP: assert property (rd && reg_addr == 3'h6 && ok && lb |=> rd_data[7:4] == $past(lp))
    else $error("loopback status bits wrong");
endmodule // uart_ctrl_checker

bind uart_irq_fifo_modem_ctrl uart_ctrl_checker u_uart_ctrl_checker (
  .mclk, .sys_rst, .chip_sel, .reg_addr, .wr_stb, .rd_stb, .wr_data, .rd_data, .irq_out, .dtr_n, .rts_n,
  .user_output_1_n, .user_output_2_n, .serial_tx_pin, .serial_rx_pin, .tx_shift_out, .rx_serial_in
);

// ==== tb/modem_model.sv ====
// Purpose: data set stand-in on the modem and serial lines
// Assumes: bench asks for line states, active high meaning on
// Notes: serial line idles at mark like a pulled-up wire
`timescale 1ns/1ps
module modem_model (
  input wire mclk,
  input wire [3:0] line_want,
  input wire rx_want,
  output reg cts_n,
  output reg dsr_n,
  output reg ring_n,
  output reg carrier_detect_in_n,
  output reg serial_rx_pin
);
  initial begin
    {carrier_detect_in_n, ring_n, dsr_n, cts_n} = 4'hF;
    serial_rx_pin = 1'b1;
  end
  // lines move on the falling edge, away from the sampling edge
  always @(negedge mclk) begin
    {carrier_detect_in_n, ring_n, dsr_n, cts_n} <= ~line_want;
    serial_rx_pin <= rx_want;
  end
endmodule // modem_model

// ==== tb/uart_irq_fifo_modem_ctrl_tb.sv ====
// Purpose: self-checking bench for the serial control block
// Assumes: ten bits per character, receiver tick every other cycle
// Notes: fixed seed keeps random register values repeatable
`timescale 1ns/1ps
module uart_irq_fifo_modem_ctrl_tb;
  reg mclk = 1'b0;
  reg sys_rst = 1'b1;
  reg chip_sel = 1'b0;
  reg wr_stb = 1'b0;
  reg rd_stb = 1'b0;
  reg [2:0] reg_addr = 3'h0;
  reg [7:0] wr_data = 8'h00;
  reg tx_shift_out = 1'b1;
  reg rx_tick16 = 1'b0;
  reg rx_char_valid = 1'b0;
  reg [7:0] rx_char_data = 8'h00;
  reg tx_char_ready = 1'b0;
  reg [3:0] line_want = 4'h0;
  reg rx_want = 1'b1;
  reg line_err = 1'b0;
  reg [3:0] char_bits = 4'hA;
  reg [7:0] d;
  reg [7:0] r;
  reg [19:0] wv = 20'h0A041;
  reg [39:0] ev = 40'h0AAA044111;
  integer n_fail = 0;
  integer tests_run = 0;
  integer seed = 32'hACEA;
  integer cyc = 0;
  integer i;
  integer k;
  wire [7:0] rd_data;
  wire [7:0] tx_char_data;
  wire irq_out, rx_dma_request_n, tx_dma_request_n, dtr_n, rts_n, user_output_1_n;
  wire user_output_2_n, cts_n, dsr_n, ring_n, carrier_detect_in_n, serial_tx_pin;
  wire serial_rx_pin, rx_serial_in, rx_char_ready, tx_char_valid;

  uart_irq_fifo_modem_ctrl u_uart_irq_fifo_modem_ctrl (
    .mclk, .sys_rst, .chip_sel, .reg_addr, .wr_stb, .rd_stb, .wr_data, .rd_data, .irq_out,
    .rx_dma_request_n, .tx_dma_request_n, .dtr_n, .rts_n, .user_output_1_n, .user_output_2_n,
    .cts_n, .dsr_n, .ring_n, .carrier_detect_in_n, .serial_tx_pin, .serial_rx_pin, .tx_shift_out,
    .rx_serial_in, .rx_tick16, .char_bits, .line_err_pending(line_err), .rx_char_valid,
    .rx_char_data, .rx_char_ready, .tx_char_valid, .tx_char_data, .tx_char_ready
  );
  modem_model u_modem_model (
    .mclk, .line_want, .rx_want, .cts_n, .dsr_n, .ring_n, .carrier_detect_in_n, .serial_rx_pin
  );

  always #5 mclk = ~mclk;
  // ticks, wandering serial bits and the hang guard
  always @(negedge mclk) begin
    cyc = cyc + 1;
    rx_tick16 <= ~rx_tick16;
    tx_shift_out <= cyc[0] ^ cyc[3];
    rx_want <= cyc[2];
    if (cyc == 30000) begin
      n_fail = n_fail + 1;
      test_done;
    end
  end

  function integer lvl(input [1:0] c);
    lvl = (c == 2'h0) ? 1 : (c == 2'h1) ? 4 : (c == 2'h2) ? 8 : 14;
  endfunction

  task test_done;
    begin
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
        $display("STATUS OK");
      else
        $display("STATUS NOT OK");
      $finish;
    end
  endtask

  task chk(input [7:0] got, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        $display("Error at %0t: got %h expected %h", $time, got, exp);
        n_fail = n_fail + 1;
      end
    end
  endtask

  // one register access; read data lands one edge later
  task bus(input w, input [2:0] a, input [7:0] v);
    begin
      @(negedge mclk);
      chip_sel = 1'b1;
      reg_addr = a;
      wr_data = v;
      wr_stb = w;
      rd_stb = !w;
      @(negedge mclk);
      chip_sel = 1'b0;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      r = rd_data;
    end
  endtask

  task rdc(input [2:0] a, input [7:0] e);
    begin
      bus(1'b0, a, 8'h00);
      chk(r, e);
    end
  endtask

  task irqc(input e);
    begin
      repeat (2) @(negedge mclk);
      chk({7'h00, irq_out}, {7'h00, e});
    end
  endtask

  task push(input integer n);
    begin
      repeat (n) begin
        @(negedge mclk);
        rx_char_valid = 1'b1;
        rx_char_data = 8'($random(seed));
        @(negedge mclk);
        rx_char_valid = 1'b0;
      end
      repeat (3) @(negedge mclk);
    end
  endtask

  initial begin
    repeat (16) @(negedge mclk);
    sys_rst = 1'b0;
    rdc(3'h1, 8'h00);
    rdc(3'h4, 8'h00);
    rdc(3'h2, 8'h01);
    // random values; reserved bits read zero, pins inverted
    for (i = 0; i < 8; i = i + 1) begin
      d = 8'($random(seed));
      bus(1'b1, 3'h1, d);
      bus(1'b1, 3'h7, ~d);
      bus(1'b1, 3'h4, d & 8'hEF);
      rdc(3'h1, d & 8'h0F);
      rdc(3'h7, ~d);
      rdc(3'h4, d & 8'h0F);
      chk({4'h0, user_output_2_n, user_output_1_n, rts_n, dtr_n}, {4'h0, ~d[3:0]});
    end
    bus(1'b1, 3'h4, 8'h00);
    bus(1'b1, 3'h1, 8'h08);
    // each line change except ring turning on raises a flag and the modem interrupt
    for (i = 0; i < 5; i = i + 1) begin
      line_want <= wv[i*4 +: 4];
      repeat (6) @(negedge mclk);
      irqc(1'b1);
      rdc(3'h6, ev[i*8 +: 8]);
    end
    rdc(3'h6, 8'h00);
    irqc(1'b0);
    // loopback: outside lines ignored, control bits loop back
    bus(1'b1, 3'h4, 8'h10);
    line_want <= 4'hF;
    repeat (6) @(negedge mclk);
    rdc(3'h6, 8'h00);
    chk({7'h00, serial_tx_pin}, 8'h01);
    bus(1'b1, 3'h4, 8'h11);
    // control bit, status sample, change flag and interrupt pin each add a register stage
    repeat (2) @(negedge mclk);
    irqc(1'b1);
    rdc(3'h6, 8'h22);
    bus(1'b1, 3'h4, 8'h1E);
    repeat (6) @(negedge mclk);
    rdc(3'h6, 8'hDB);
    bus(1'b1, 3'h4, 8'h00);
    line_want <= 4'h0;
    repeat (6) @(negedge mclk);
    bus(1'b0, 3'h6, 8'h00);
    bus(1'b0, 3'h6, 8'h00);
    // fifo control needs bit 0; trigger levels gate rx interrupt
    bus(1'b1, 3'h2, 8'hC0);
    rdc(3'h2, 8'h01);
    bus(1'b1, 3'h1, 8'h01);
    for (k = 0; k < 4; k = k + 1) begin
      bus(1'b1, 3'h2, {k[1:0], 6'h03});
      push(lvl(k[1:0]) - 1);
      irqc(1'b0);
      push(1);
      irqc(1'b1);
      rdc(3'h2, 8'hC4);
      bus(1'b0, 3'h0, 8'h00);
      irqc(1'b0);
    end
    // idle fifo with data times out, a read clears it
    repeat (1000) @(negedge mclk);
    irqc(1'b0);
    repeat (400) @(negedge mclk);
    irqc(1'b1);
    rdc(3'h2, 8'hCC);
    bus(1'b0, 3'h0, 8'h00);
    irqc(1'b0);
    // polling: fill to refusal, no interrupt shown
    bus(1'b1, 3'h1, 8'h00);
    push(4);
    chk({7'h00, rx_char_ready}, 8'h00);
    irqc(1'b0);
    rdc(3'h5, 8'h61);
    bus(1'b1, 3'h2, 8'hC3);
    rdc(3'h5, 8'h60);
    // dma request modes
    push(1);
    chk({7'h00, rx_dma_request_n}, 8'h00);
    bus(1'b1, 3'h2, 8'hC9);
    repeat (2) @(negedge mclk);
    chk({7'h00, rx_dma_request_n}, 8'h01);
    push(13);
    chk({7'h00, rx_dma_request_n}, 8'h00);
    // tx flush keeps rx, drain empties, disable clears all
    bus(1'b1, 3'h0, 8'h5A);
    bus(1'b1, 3'h0, 8'hA5);
    chk(tx_char_data, 8'h5A);
    // mode 1 transmit request goes inactive only once the fifo is full
    for (i = 0; i < 14; i = i + 1) begin
      bus(1'b1, 3'h0, i[7:0]);
    end
    @(negedge mclk);
    chk({7'h00, tx_dma_request_n}, 8'h01);
    bus(1'b1, 3'h2, 8'hC5);
    rdc(3'h5, 8'h61);
    chk({7'h00, tx_dma_request_n}, 8'h00);
    bus(1'b1, 3'h0, 8'h3C);
    @(negedge mclk);
    chk({6'h00, tx_char_valid, tx_dma_request_n}, 8'h03);
    tx_char_ready = 1'b1;
    repeat (4) @(negedge mclk);
    tx_char_ready = 1'b0;
    rdc(3'h5, 8'h61);
    bus(1'b1, 3'h2, 8'h00);
    rdc(3'h5, 8'h60);
    rdc(3'h2, 8'h01);
    // enabling keeps what char mode already holds
    push(1);
    bus(1'b1, 3'h2, 8'h01);
    rdc(3'h5, 8'h61);
    // tx empty and line status sources, each behind its own enable
    bus(1'b1, 3'h1, 8'h02);
    irqc(1'b1);
    rdc(3'h2, 8'hC2);
    irqc(1'b0);
    line_err = 1'b1;
    irqc(1'b0);
    bus(1'b1, 3'h1, 8'h04);
    irqc(1'b1);
    rdc(3'h2, 8'hC6);
    bus(1'b1, 3'h1, 8'h00);
    irqc(1'b0);
    rdc(3'h2, 8'hC1);
    test_done;
  end
endmodule // uart_irq_fifo_modem_ctrl_tb
